/* File: hdl/ieinj_pkg.sv */
package ieinj_pkg;

  // Register byte offsets
  localparam logic [11:0] IEINJ_INJECT_OFFSET = 12'h490;
  localparam logic [11:0] IEINJ_STATUS_OFFSET = 12'h494;
  localparam logic [11:0] IEINJ_MASK_OFFSET = 12'h498;
  localparam logic [11:0] IEINJ_SEVERITY_OFFSET = 12'h49C;
  localparam logic [11:0] IEINJ_IRQ_STATUS_OFFSET = 12'h4A0;
  localparam logic [11:0] IEINJ_IRQ_MASK_OFFSET = 12'h4A4;

  // Field layout
  localparam int IEINJ_NUM_CLASSES = 19;
  localparam logic [31:0] IEINJ_VALID_BITS = 32'h0007_FFF7;
  localparam logic [31:0] IEINJ_INJECT_READ_VALUE = 32'h0000_0000;

  // Reset values
  localparam logic [31:0] IEINJ_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] IEINJ_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] IEINJ_SEVERITY_RESET = 32'h0004_D510;
  localparam logic [1:0] IEINJ_IRQ_STATUS_RESET = 2'h0;
  localparam logic [1:0] IEINJ_IRQ_MASK_RESET = 2'h0;

  // Interrupt status bit positions
  localparam int IEINJ_IRQ_CORR_BIT = 0;
  localparam int IEINJ_IRQ_UNCORR_BIT = 1;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ieinj_wb_req_t;

  // Error report bundle
  typedef struct packed {
    logic corr;
    logic uncorr;
  } ieinj_report_t;

endpackage

/* File: hdl/ieinj_top.sv */
`timescale 1ns/10ps
module ieinj_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ieinj_pkg::ieinj_wb_req_t wb_req_i,
  input wire logic [31:0] hw_err_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output ieinj_pkg::ieinj_report_t report_o,
  output logic irq_o
);
  import ieinj_pkg::*;

  // Register map of this bank, all 32-bit words on byte offsets:
  //   injection   write-only strobes, reads zero, sets status flags
  //   status      sticky flags, write one to clear, set by events or injection
  //   mask        one masks a flag out of both report classes
  //   severity    one reports a flag as uncorrectable, zero as correctable
  //   irq status  bit 0 correctable, bit 1 uncorrectable, sticky, write one to clear
  //   irq mask    one lets the matching sticky bit drive the interrupt
  // Reserved bit positions read zero and ignore writes in every word.
  // A write takes effect on the edge that accepts it; the answer follows
  // one cycle later, so a read issued right after a write sees the new value.
  // Hardware error inputs come from logic on this clock and need no
  // synchronising; a bit held high keeps setting its flag every cycle.
  // Trade-off: the bus answers a cycle after it accepts a request, which
  // costs a cycle per access but keeps every bus output on a flip-flop.

  // Sticky error flags
  logic [31:0] status_reg;
  logic [31:0] status_next;

  // Per-flag mask, one meaning masked
  logic [31:0] mask_reg;
  logic [31:0] mask_next;

  // Per-flag severity, one meaning uncorrectable
  logic [31:0] sev_reg;
  logic [31:0] sev_next;

  // Sticky interrupt bits and their enables
  logic [1:0] irq_sts_reg;
  logic [1:0] irq_sts_next;
  logic [1:0] irq_msk_reg;
  logic [1:0] irq_msk_next;

  // Bus answer: read word, acknowledge and error
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;

  // Registered report levels
  ieinj_report_t report_reg;
  ieinj_report_t report_next;

  // Request qualification and address decode
  logic access;
  logic wr_stb;
  logic hit;
  logic sel_inject;
  logic sel_status;
  logic sel_mask;
  logic sel_sev;
  logic sel_irq_sts;
  logic sel_irq_msk;

  // Write data after byte lanes and reserved bits
  logic [31:0] byte_mask;
  logic [31:0] wr_bits;

  // Set and clear terms, one bit per flag
  logic [31:0] inject_set;
  logic [31:0] hw_set;
  logic [31:0] status_clr;
  logic [31:0] flag_set;
  logic [31:0] flag_clr;

  // Report routing and interrupt edges
  logic [31:0] active;
  logic [31:0] corr_vec;
  logic [31:0] uncorr_vec;
  logic [1:0] irq_clr;
  logic [1:0] irq_rise;

  // Byte enables expanded to a bit mask, one lane per generate pass; the
  // injection word honours them too, so a partial write injects only its lanes
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign byte_mask[lane*8 +: 8] = {8{wb_req_i.sel[lane]}};
    end
  endgenerate

  // New access only while no answer is outstanding; a master that keeps
  // its strobe up past the answer is taken again, so it must drop it
  assign access = wb_req_i.cyc && wb_req_i.stb && !ack_reg && !err_reg;
  assign wr_stb = access && wb_req_i.we;
  // Deselected byte lanes and reserved bit positions never reach state
  assign wr_bits = wb_req_i.dat & byte_mask & IEINJ_VALID_BITS;

  // Address decoder shared by the write and read paths; one select at most
  always_comb begin
    sel_inject = 1'b0;
    sel_status = 1'b0;
    sel_mask = 1'b0;
    sel_sev = 1'b0;
    sel_irq_sts = 1'b0;
    sel_irq_msk = 1'b0;
    if (wb_req_i.adr == IEINJ_INJECT_OFFSET) begin
      sel_inject = 1'b1;
    end else if (wb_req_i.adr == IEINJ_STATUS_OFFSET) begin
      sel_status = 1'b1;
    end else if (wb_req_i.adr == IEINJ_MASK_OFFSET) begin
      sel_mask = 1'b1;
    end else if (wb_req_i.adr == IEINJ_SEVERITY_OFFSET) begin
      sel_sev = 1'b1;
    end else if (wb_req_i.adr == IEINJ_IRQ_STATUS_OFFSET) begin
      sel_irq_sts = 1'b1;
    end else if (wb_req_i.adr == IEINJ_IRQ_MASK_OFFSET) begin
      sel_irq_msk = 1'b1;
    end
  end

  // Unmapped offsets fall through to the error answer
  assign hit = sel_inject || sel_status || sel_mask
    || sel_sev || sel_irq_sts || sel_irq_msk;

  // Injection is a pure write strobe; only ones set, zeros leave flags alone
  assign inject_set = (wr_stb && sel_inject) ?
    wr_bits : 32'h0000_0000;
  // Write-one-to-clear terms of the status flags
  assign status_clr = (wr_stb && sel_status) ? wr_bits : 32'h0000_0000;
  // Real hardware events share the set path with injection; each cycle
  // high sets the flag, so a held level simply keeps it set
  assign hw_set = hw_err_i & IEINJ_VALID_BITS;
  assign active = status_reg & ~mask_reg;

  // Per-flag set, clear and report routing; reserved positions are tied off
  genvar flag;
  generate
    for (flag = 0; flag < 32; flag++) begin : g_flag
      if (IEINJ_VALID_BITS[flag]) begin : g_live
        assign flag_set[flag] = inject_set[flag] | hw_set[flag];
        assign flag_clr[flag] = status_clr[flag];
      end else begin : g_tied
        // Nothing can set a reserved flag, so it always reads zero
        assign flag_set[flag] = 1'b0;
        assign flag_clr[flag] = 1'b1;
      end
      // Severity steers each unmasked flag to exactly one report class
      assign uncorr_vec[flag] = active[flag] & sev_reg[flag];
      assign corr_vec[flag] = active[flag] & ~sev_reg[flag];
    end
  endgenerate

  // Status flags: set wins over a same-cycle write-one-to-clear, so an
  // event is never lost; reserved positions clear every cycle
  always_comb begin
    status_next = (status_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= IEINJ_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Mask and severity: plain read-write words, byte lanes honoured
  always_comb begin
    mask_next = mask_reg;
    sev_next = sev_reg;
    if (wr_stb && sel_mask) begin
      mask_next = (mask_reg & ~byte_mask) | wr_bits;
    end else if (wr_stb && sel_sev) begin
      sev_next = (sev_reg & ~byte_mask) | wr_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= IEINJ_MASK_RESET;
      sev_reg <= IEINJ_SEVERITY_RESET;
    end else begin
      mask_reg <= mask_next;
      sev_reg <= sev_next;
    end
  end

  // Write-one-to-clear terms of the sticky interrupt bits, low byte only
  assign irq_clr = (wr_stb && sel_irq_sts && wb_req_i.sel[0]) ? wb_req_i.dat[1:0] : 2'h0;

  // Interrupt group: report levels, sticky bits set on a rising report, mask
  always_comb begin
    report_next.uncorr = |uncorr_vec;
    report_next.corr = |corr_vec;
    // Only a rising report sets a sticky bit, so a flag left standing
    // does not re-raise the interrupt after software clears it
    irq_rise = 2'h0;
    irq_rise[IEINJ_IRQ_CORR_BIT] = report_next.corr && !report_reg.corr;
    irq_rise[IEINJ_IRQ_UNCORR_BIT] = report_next.uncorr && !report_reg.uncorr;
    // Set beats clear so an edge in the clearing cycle is not lost
    irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_rise;
    irq_msk_next = irq_msk_reg;
    if (wr_stb && sel_irq_msk && wb_req_i.sel[0]) begin
      irq_msk_next = wb_req_i.dat[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts_reg <= IEINJ_IRQ_STATUS_RESET;
      irq_msk_reg <= IEINJ_IRQ_MASK_RESET;
      report_reg <= '0;
    end else begin
      irq_sts_reg <= irq_sts_next;
      irq_msk_reg <= irq_msk_next;
      report_reg <= report_next;
    end
  end

  // Bus answer: one-cycle ack for a mapped offset, err for anything else,
  // so a stray access never leaves the master waiting
  always_comb begin
    ack_next = access && hit;
    err_next = access && !hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  // Read multiplexer; the word stands only in the answer cycle and is zero
  // otherwise, so stale data never lingers on the bus
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (access && !wb_req_i.we) begin
      if (sel_inject) begin
        rdata_next = IEINJ_INJECT_READ_VALUE;
      end else if (sel_status) begin
        rdata_next = status_reg;
      end else if (sel_mask) begin
        rdata_next = mask_reg;
      end else if (sel_sev) begin
        rdata_next = sev_reg;
      end else if (sel_irq_sts) begin
        rdata_next = {30'h0000_0000, irq_sts_reg};
      end else if (sel_irq_msk) begin
        rdata_next = {30'h0000_0000, irq_msk_reg};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs come straight from flip-flops, except the interrupt level
  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;
  assign report_o = report_reg;
  // Level interrupt while any enabled sticky bit is set; it stays up until
  // software clears or masks the sticky bit, even after the flag itself is cleared
  assign irq_o = |(irq_sts_reg & irq_msk_reg);

endmodule

/* File: verif/ieinj_top_sva.sv */
`timescale 1ns/10ps
module ieinj_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ieinj_pkg::ieinj_wb_req_t wb_req_i,
  input wire logic [31:0] hw_err_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire ieinj_pkg::ieinj_report_t report_o,
  input wire logic irq_o
);
  import ieinj_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk;
  logic inj;
  // Request taken, and a write to the injection register
  assign tk = wb_req_i.cyc & wb_req_i.stb & !wb_ack_o & !wb_err_o;
  assign inj = tk & wb_req_i.we & (wb_req_i.adr == IEINJ_INJECT_OFFSET);
  AST_ANSWER: assert property (tk |=> wb_ack_o | wb_err_o) else $error("no answer");
  AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_EXCL: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  AST_ZERO_READ: assert property (tk && !wb_req_i.we && wb_req_i.adr == IEINJ_INJECT_OFFSET
    |=> wb_dat_o == 32'h0) else $error("inject reads nonzero");
  AST_UNMAPPED: assert property (tk && wb_req_i.adr[11:8] != 4'h4 |=> wb_err_o)
    else $error("no err");
  // Bit 0 is correctable and bit 8 uncorrectable out of reset
  AST_INJ_CORR: assert property (inj && wb_req_i.dat[0] && wb_req_i.sel[0]
    |-> ##[1:3] report_o.corr) else $error("no corr report");
  AST_INJ_UNCORR: assert property (inj && wb_req_i.dat[8] && wb_req_i.sel[1]
    |-> ##[1:3] report_o.uncorr) else $error("no uncorr report");
  AST_HW_SET: assert property (hw_err_i[15] |-> ##[1:2] report_o.uncorr)
    else $error("hw event lost");
  AST_RST: assert property ($fell(rst_i) |-> !wb_ack_o && !report_o.corr && !irq_o)
    else $error("outputs after reset");
endmodule
bind ieinj_top ieinj_chk ieinj_chk_i (.clk_i, .rst_i, .wb_req_i, .hw_err_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .report_o, .irq_o);

/* File: verif/test_ieinj_top.sv */
`timescale 1ns/10ps
module test_ieinj_top;
  import ieinj_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  ieinj_wb_req_t req = '0;
  logic [31:0] hw_err_i = '0;
  logic [31:0] wb_dat_o, st, hv;
  logic wb_ack_o, wb_err_o, irq_o;
  ieinj_report_t report_o;
  logic [33:0] q[$];
  logic [33:0] ex;
  logic [15:0] r = 16'h31AC;
  int errors = 0, n_tests = 0, cyc_n = 0;
  ieinj_top ieinj_top_i (.clk_i, .rst_i, .wb_req_i(req), .hw_err_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .report_o, .irq_o);
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Expectation is {check data, expect err, data}; waits for the answer
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [33:0] e);
    q.push_back(e);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 34'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, {2'b10, e});
  endtask
  // Monitor pairs each answer with the oldest note; also cuts a hang short
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      errors++;
      tally_and_finish();
    end
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      ex = q.pop_front();
      chk("bus err", {31'h0, wb_err_o}, {31'h0, ex[32]});
      if (ex[33]) chk("read data", wb_dat_o, ex[31:0]);
    end
  end
  // Main sequence: every bit position, masking, hardware events, interrupt
  initial begin
    st = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IEINJ_SEVERITY_OFFSET, IEINJ_SEVERITY_RESET);
    for (int i = 0; i < 32; i++) begin
      wr(IEINJ_INJECT_OFFSET, 32'h1 << i);
      st = st | ((32'h1 << i) & IEINJ_VALID_BITS);
      rd(IEINJ_STATUS_OFFSET, st);
      rd(IEINJ_INJECT_OFFSET, 32'h0);
    end
    wr(IEINJ_INJECT_OFFSET, 32'h0);
    rd(IEINJ_STATUS_OFFSET, st);
    chk("report", {30'h0, report_o}, 32'h3);
    wr(IEINJ_MASK_OFFSET, 32'hFFFFFFFF);
    repeat (2) @(posedge clk_i);
    chk("masked report", {30'h0, report_o}, 32'h0);
    wr(IEINJ_STATUS_OFFSET, 32'hFFFFFFFF);
    wr(IEINJ_MASK_OFFSET, 32'h0);
    r = lf(r);
    hv = {r, lf(r)};
    hw_err_i <= hv;
    @(posedge clk_i);
    hw_err_i <= '0;
    rd(IEINJ_STATUS_OFFSET, hv & IEINJ_VALID_BITS);
    wr(IEINJ_STATUS_OFFSET, 32'hFFFFFFFF);
    wr(IEINJ_IRQ_STATUS_OFFSET, 32'h3);
    wr(IEINJ_IRQ_MASK_OFFSET, 32'h3);
    chk("irq idle", {31'h0, irq_o}, 32'h0);
    wr(IEINJ_INJECT_OFFSET, 32'h100);
    repeat (3) @(posedge clk_i);
    chk("irq set", {31'h0, irq_o}, 32'h1);
    wr(IEINJ_IRQ_MASK_OFFSET, 32'h0);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    wr(IEINJ_IRQ_STATUS_OFFSET, 32'h3);
    wr(IEINJ_IRQ_MASK_OFFSET, 32'h3);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    bus(1'b0, 12'h5F0, 32'h0, {2'b01, 32'h0});
    tally_and_finish();
  end
endmodule
